// ===== rtl/tecs_sequencer.sv
`timescale 1ns/10ps
`include "tecs_params.svh"

// Function
// RL1 - Controller holds each start or stop pulse at least 5 ms.
// RL2 - Start or stop is seen within 5 ms, plus 500 ms after voltage change.
// RL3 - Response delay precedes measuring: automatic, or 5 ms to 999.9 s.
// RL4 - Measurement lasts 30, 80 or 480 ms by speed and contact check.
// RL5 - Measurements repeat every 50, 100 or 500 ms by speed and contact check.
// RL6 - Discharge brings output below 10 V within at most 20 ms.
// RL7 - Enabled duration ends the test after 45 ms to 999.9 s.
// RL8 - Halt-on-fail without duration keeps testing until a fail judgment.
// RL9 - Halt-on-fail with duration starts on either start and runs the duration.
// RL10 - Forced mode ignores duration; runs from a start until a stop.
// RL11 - Test output is low during a test, high after; two release timings.
// RL12 - Slow release keeps test output low until discharge reaches about 10 V.
// RL13 - Fast release raises test output at completion, ignoring discharge.
// RL14 - Manual check forces each output by hand and reports every input.
// RL15 - Condition selects are latched at start and ignored during a test.
// RL16 - Source wiring follows contact state; sink wiring inverts levels. Condition selects are not inverted here.
// RL17 - Delay once, then measurement cycles until termination, then discharge.
module tecs_sequencer
    import tecs_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = `TECS_MS_NS / `TECS_CLK_PERIOD_NS,
    parameter int unsigned COND_W        = 4
) (
    input  wire logic              ref_clk_in,       // System clock, 100 MHz.
    input  wire logic              rst_in,           // Async reset, active high.
    input  wire logic [7:0]        addr_in,          // Register byte address.
    input  wire logic [31:0]       wr_data_in,       // Write data.
    input  wire logic              wr_in,            // Write strobe.
    input  wire logic              rd_in,            // Read strobe.
    output logic      [31:0]       rd_data_out,      // Read data, cycle after strobe.
    input  wire logic              start_pin_in,     // External start pin level.
    input  wire logic              stop_pin_in,      // External stop pin level.
    input  wire logic [COND_W-1:0] cond_pin_in,      // External condition selects.
    input  wire logic              below_10v_in,     // Discharge comparator.
    input  wire logic              panel_start_in,   // Panel start key pulse.
    input  wire logic              panel_stop_in,    // Panel stop key pulse.
    input  wire logic              fail_judge_in,    // Fail judgment pulse.
    input  wire logic              volt_change_in,   // Test voltage changed pulse.
    output logic                   test_pin_out,     // Test-in-progress pin level.
    output logic                   hv_on_out,        // Apply test voltage.
    output logic                   meas_out,         // Measurement window.
    output logic                   disch_out,        // Discharge switch.
    output logic      [COND_W-1:0] cond_latched_out, // Conditions held for the test.
    output tecs_state_t            state_out         // Current phase.
);

    localparam int SW = COND_W + 3;

    // Keeps a millisecond setting inside its legal span.
    function automatic logic [`TECS_MS_W-1:0] clamp_ms(input logic [`TECS_MS_W-1:0] v,
                                                      input logic [`TECS_MS_W-1:0] lo,
                                                      input logic [`TECS_MS_W-1:0] hi);
        clamp_ms = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp_ms

    logic [`TECS_CTRL_W-1:0] ctrl_reg;
    logic [`TECS_MS_W-1:0]   delay_reg;
    logic [`TECS_MS_W-1:0]   duration_reg;
    logic [3:0]              manual_reg;
    logic [SW-1:0]           sync1_reg;
    logic [SW-1:0]           sync2_reg;
    logic [1:0]              prev_reg;
    logic                    start_pend_reg;
    logic                    disch_tmo_reg;
    logic                    slow_lat_reg;
    logic                    cc_lat_reg;
    logic                    timer_lat_reg;
    logic                    rel_slow_lat_reg;
    tecs_mode_t              mode_lat_reg;
    tecs_state_t             state_reg;
    tecs_state_t             state_next;
    logic                    phase_load;
    logic [`TECS_MS_W-1:0]   phase_val;
    logic                    phase_done;
    logic                    phase_busy;
    logic                    dur_load;
    logic                    dur_done;
    logic                    settle_busy;
    logic                    sink;
    logic                    io_check;
    logic                    ext_start_on;
    logic                    ext_stop_on;
    logic                    below_10v;
    logic                    start_evt;
    logic                    stop_evt;
    logic                    accept;
    logic                    end_req;
    logic                    test_on_next;
    logic [`TECS_MS_W-1:0]   meas_ms;
    logic [`TECS_MS_W-1:0]   gap_ms;

    assign sink     = ctrl_reg[`TECS_CTRL_SINK];
    assign io_check = ctrl_reg[`TECS_CTRL_IO_CHECK];

    // Register writes; sink, manual check and manual bits act at once; other settings take effect at the next start, where they are read.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg     <= `TECS_CTRL_RST;
            delay_reg    <= `TECS_DELAY_RST;
            duration_reg <= `TECS_DURATION_RST;
            manual_reg   <= `TECS_MANUAL_RST;
        end else if (wr_in) begin
            case (addr_in)
                `TECS_ADDR_CTRL:     ctrl_reg     <= wr_data_in[`TECS_CTRL_W-1:0];
                `TECS_ADDR_DELAY:    delay_reg    <= wr_data_in[`TECS_MS_W-1:0];
                `TECS_ADDR_DURATION: duration_reg <= wr_data_in[`TECS_MS_W-1:0];
                `TECS_ADDR_MANUAL:   manual_reg   <= wr_data_in[3:0];
                default:             ;
            endcase
        end
    end

    // Read data stands for one cycle only; unmapped addresses read zero.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 32'h0000_0000;
        end else if (rd_in) begin
            case (addr_in)
                `TECS_ADDR_CTRL:     rd_data_out <= 32'(ctrl_reg);
                `TECS_ADDR_DELAY:    rd_data_out <= 32'(delay_reg);
                `TECS_ADDR_DURATION: rd_data_out <= 32'(duration_reg);
                `TECS_ADDR_MANUAL:   rd_data_out <= 32'(manual_reg);
                `TECS_ADDR_STATUS:   rd_data_out <= 32'({disch_tmo_reg, below_10v, cond_latched_out,
                                                        sync2_reg[COND_W+2:3], ext_stop_on,
                                                        ext_start_on, state_reg}); // [RL14]
                default:             rd_data_out <= 32'h0000_0000;
            endcase
        end else begin
            rd_data_out <= 32'h0000_0000;
        end
    end

    // Pins cross into the clock domain through two flip-flops; prev_reg reads only the second.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= 2'b00;
        end else begin
            sync1_reg <= {cond_pin_in, below_10v_in, stop_pin_in, start_pin_in};
            sync2_reg <= sync1_reg;
            prev_reg  <= {ext_stop_on, ext_start_on};
        end
    end

    // Sink wiring inverts the pin level against the contact state.
    assign ext_start_on = sync2_reg[0] ^ sink;                                 // [RL16]
    assign ext_stop_on  = sync2_reg[1] ^ sink;                                 // [RL16]
    assign below_10v    = sync2_reg[2];
    // An edge is enough: a 5 ms pulse is seen about three cycles after it begins.
    assign start_evt = (ext_start_on & ~prev_reg[0]) | panel_start_in;         // [RL2] [RL1]
    assign stop_evt  = (ext_stop_on & ~prev_reg[1]) | panel_stop_in;           // [RL2]

    // Start waits here while the voltage change settles, adding up to 500 ms.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            start_pend_reg <= 1'b0;
        end else if (accept || state_reg != TECS_IDLE || io_check) begin
            start_pend_reg <= 1'b0;
        end else if (start_evt) begin
            start_pend_reg <= 1'b1;                                            // [RL2]
        end
    end

    assign accept = (state_reg == TECS_IDLE) && start_pend_reg && !settle_busy && !io_check;

    // Speed, contact check, timer, release, mode and condition selects are frozen for the whole test.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            slow_lat_reg     <= 1'b0;
            cc_lat_reg       <= 1'b0;
            timer_lat_reg    <= 1'b0;
            rel_slow_lat_reg <= 1'b0;
            mode_lat_reg     <= TECS_MODE_CONT;
            cond_latched_out <= '0;
        end else if (accept) begin
            slow_lat_reg     <= ctrl_reg[`TECS_CTRL_SLOW];
            cc_lat_reg       <= ctrl_reg[`TECS_CTRL_CONTACT];
            timer_lat_reg    <= ctrl_reg[`TECS_CTRL_TIMER];
            rel_slow_lat_reg <= ctrl_reg[`TECS_CTRL_REL_SLOW];
            mode_lat_reg     <= tecs_mode_t'(ctrl_reg[`TECS_CTRL_MODE_HI:`TECS_CTRL_MODE_LO]);
            cond_latched_out <= sync2_reg[COND_W+2:3];                         // [RL15]
        end
    end

    // Measurement time and the rest of the interval follow speed and contact check.
    assign meas_ms = slow_lat_reg ? `TECS_MEAS_SLOW_MS :
                     (cc_lat_reg ? `TECS_MEAS_FAST_CC_MS : `TECS_MEAS_FAST_MS); // [RL4]
    assign gap_ms  = slow_lat_reg ? (`TECS_INT_SLOW_MS - `TECS_MEAS_SLOW_MS) :
                     (cc_lat_reg ? (`TECS_INT_FAST_CC_MS - `TECS_MEAS_FAST_CC_MS) :
                      (`TECS_INT_FAST_MS - `TECS_MEAS_FAST_MS));               // [RL5]

    // A stop always ends a test; duration and fail depend on the mode.
    assign end_req = stop_evt || dur_done ||                                   // [RL7] [RL9] [RL10]
                     (mode_lat_reg == TECS_MODE_FAIL && !timer_lat_reg && fail_judge_in); // [RL8]
    assign dur_load = accept && ctrl_reg[`TECS_CTRL_TIMER] &&
                      ctrl_reg[`TECS_CTRL_MODE_HI:`TECS_CTRL_MODE_LO] != TECS_MODE_FORCED; // [RL10]

    // Phase sequencing and the phase timer load.
    always_comb begin
        state_next = state_reg;
        phase_load = 1'b0;
        phase_val  = meas_ms;
        case (state_reg)
            TECS_IDLE: begin
                if (accept) begin
                    state_next = TECS_DELAY;
                    phase_load = 1'b1;
                    phase_val  = (delay_reg == '0) ? `TECS_AUTO_DELAY_MS :
                                 clamp_ms(delay_reg, `TECS_DELAY_MIN_MS, `TECS_DELAY_MAX_MS); // [RL3]
                end
            end
            TECS_DELAY, TECS_MEAS, TECS_GAP: begin
                if (end_req) begin
                    state_next = TECS_DISCH;                                   // [RL17]
                    phase_load = 1'b1;
                    phase_val  = `TECS_DISCH_MAX_MS;                           // [RL6]
                end else if (phase_done) begin
                    state_next = (state_reg == TECS_MEAS) ? TECS_GAP : TECS_MEAS; // [RL17]
                    phase_load = 1'b1;
                    phase_val  = (state_reg == TECS_MEAS) ? gap_ms : meas_ms;
                end
            end
            TECS_DISCH: begin
                if (below_10v || phase_done) begin
                    state_next = TECS_IDLE;                                    // [RL6]
                end
            end
            default: begin
                state_next = TECS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= TECS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // A discharge that hits its 20 ms limit above 10 V is kept until the next start.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            disch_tmo_reg <= 1'b0;
        end else if (state_reg == TECS_DISCH && phase_done && !below_10v) begin
            disch_tmo_reg <= 1'b1;                                             // [RL6]
        end else if (accept) begin
            disch_tmo_reg <= 1'b0;
        end
    end

    tecs_ms_timer #(
        .TICK_CYCLES (CYCLES_PER_MS),
        .MS_W        (`TECS_MS_W)
    ) u_phase_timer (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .load_in    (phase_load),
        .value_in   (phase_val),
        .abort_in   (1'b0),
        .done_out   (phase_done),
        .busy_out   (phase_busy)
    );

    tecs_ms_timer #(
        .TICK_CYCLES (CYCLES_PER_MS),
        .MS_W        (`TECS_MS_W)
    ) u_dur_timer (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .load_in    (dur_load),
        .value_in   (clamp_ms(duration_reg, `TECS_DUR_MIN_MS, `TECS_DUR_MAX_MS)), // [RL7]
        .abort_in   (state_next == TECS_DISCH),
        .done_out   (dur_done),
        .busy_out   ()
    );

    tecs_ms_timer #(
        .TICK_CYCLES (CYCLES_PER_MS),
        .MS_W        (`TECS_MS_W)
    ) u_settle_timer (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .load_in    (volt_change_in),
        .value_in   (`TECS_VSETTLE_MS),                                        // [RL2]
        .abort_in   (1'b0),
        .done_out   (),
        .busy_out   (settle_busy)
    );

    // Fast release drops the test contact as discharge begins; slow holds it to the end.
    assign test_on_next = (state_next != TECS_IDLE) &&
                          !(state_next == TECS_DISCH && !rel_slow_lat_reg);    // [RL12] [RL13]

    // Outputs are registered; in manual check while idle each follows its manual bit.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            test_pin_out <= 1'b1;
            hv_on_out    <= 1'b0;
            meas_out     <= 1'b0;
            disch_out    <= 1'b0;
            state_out    <= TECS_IDLE;
        end else begin
            state_out <= state_next;
            if (io_check && state_next == TECS_IDLE) begin
                test_pin_out <= manual_reg[`TECS_MAN_TEST] ^ sink;             // [RL14]
                hv_on_out    <= manual_reg[`TECS_MAN_HV];                      // [RL14]
                meas_out     <= manual_reg[`TECS_MAN_MEAS];
                disch_out    <= manual_reg[`TECS_MAN_DISCH];
            end else begin
                test_pin_out <= ~test_on_next ^ sink;                          // [RL11] [RL16]
                hv_on_out    <= state_next inside {TECS_DELAY, TECS_MEAS, TECS_GAP};
                meas_out     <= state_next == TECS_MEAS;
                disch_out    <= state_next == TECS_DISCH;
            end
        end
    end

    a_start_accept: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL2]
        accept |=> state_reg == TECS_DELAY && state_out == TECS_DELAY)
        else $error("accepted start did not enter delay");
    a_delay_auto: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL3]
        accept && delay_reg == '0 |-> phase_load && phase_val == `TECS_AUTO_DELAY_MS)
        else $error("auto delay not loaded");
    a_meas_len: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL4]
        phase_load && state_next == TECS_MEAS |-> phase_val == (slow_lat_reg ? 20'h0_01E0 :
            (cc_lat_reg ? 20'h0_0050 : 20'h0_001E)))
        else $error("wrong measurement time");
    a_interval_len: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL5]
        phase_load && state_next == TECS_GAP |-> phase_val + meas_ms == (slow_lat_reg ? 20'h0_01F4 :
            (cc_lat_reg ? 20'h0_0064 : 20'h0_0032)))
        else $error("wrong measurement interval");
    a_disch_limit: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL6]
        state_reg != TECS_DISCH && state_next == TECS_DISCH |-> phase_val == 20'h0_0014 ##1 disch_out)
        else $error("discharge not started with 20 ms limit");
    a_forced_notimer: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL10]
        accept && ctrl_reg[`TECS_CTRL_MODE_HI:`TECS_CTRL_MODE_LO] == TECS_MODE_FORCED |-> !dur_load)
        else $error("forced mode started the duration timer");
    a_fail_halt: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL8]
        state_reg inside {TECS_MEAS, TECS_GAP} && mode_lat_reg == TECS_MODE_FAIL && !timer_lat_reg
        && fail_judge_in |=> state_reg == TECS_DISCH)
        else $error("fail judgment did not end the test");
    a_fast_release: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL13]
        $rose(state_reg == TECS_DISCH) && !rel_slow_lat_reg && !io_check |-> test_pin_out == ~sink)
        else $error("fast release kept test output low");
    a_slow_release: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL12]
        state_reg == TECS_DISCH && rel_slow_lat_reg |-> test_pin_out == sink)
        else $error("slow release raised test output early");
    a_cond_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL15]
        state_reg != TECS_IDLE && $past(state_reg) != TECS_IDLE |-> $stable(cond_latched_out))
        else $error("conditions changed during a test");
    a_manual_out: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RL14]
        io_check && state_next == TECS_IDLE |=> hv_on_out == $past(manual_reg[`TECS_MAN_HV]))
        else $error("manual output not forced");

endmodule : tecs_sequencer

// ===== rtl/tecs_params.svh
`ifndef TECS_PARAMS_SVH
`define TECS_PARAMS_SVH

// Clock and millisecond base.
`define TECS_CLK_PERIOD_NS   32'h0000_000A
`define TECS_MS_NS           32'h000F_4240
`define TECS_MS_W            20

// Register byte offsets.
`define TECS_ADDR_CTRL       8'h00
`define TECS_ADDR_DELAY      8'h04
`define TECS_ADDR_DURATION   8'h08
`define TECS_ADDR_MANUAL     8'h0C
`define TECS_ADDR_STATUS     8'h10

// Control field positions.
`define TECS_CTRL_SLOW       0
`define TECS_CTRL_CONTACT    1
`define TECS_CTRL_TIMER      2
`define TECS_CTRL_MODE_LO    3
`define TECS_CTRL_MODE_HI    4
`define TECS_CTRL_REL_SLOW   5
`define TECS_CTRL_IO_CHECK   6
`define TECS_CTRL_SINK       7
`define TECS_CTRL_W          8

// Manual output bit positions.
`define TECS_MAN_TEST        0
`define TECS_MAN_HV          1
`define TECS_MAN_MEAS        2
`define TECS_MAN_DISCH       3

// Reset values.
`define TECS_CTRL_RST        8'h00
`define TECS_DELAY_RST       20'h0_0000
`define TECS_DURATION_RST    20'h0_0BB8
`define TECS_MANUAL_RST      4'h0

// Times in milliseconds.
`define TECS_DELAY_MIN_MS    20'h0_0005
`define TECS_DELAY_MAX_MS    20'hF_41DC
`define TECS_AUTO_DELAY_MS   20'h0_0005
`define TECS_DUR_MIN_MS      20'h0_002D
`define TECS_DUR_MAX_MS      20'hF_41DC
`define TECS_MEAS_FAST_MS    20'h0_001E
`define TECS_MEAS_FAST_CC_MS 20'h0_0050
`define TECS_MEAS_SLOW_MS    20'h0_01E0
`define TECS_INT_FAST_MS     20'h0_0032
`define TECS_INT_FAST_CC_MS  20'h0_0064
`define TECS_INT_SLOW_MS     20'h0_01F4
`define TECS_DISCH_MAX_MS    20'h0_0014
`define TECS_VSETTLE_MS      20'h0_01F4

`endif

// ===== rtl/tecs_pkg.sv
package tecs_pkg;

    // Sequencer phases.
    typedef enum logic [2:0] {
        TECS_IDLE  = 3'b000,
        TECS_DELAY = 3'b001,
        TECS_MEAS  = 3'b010,
        TECS_GAP   = 3'b011,
        TECS_DISCH = 3'b100
    } tecs_state_t;

    // Test modes.
    typedef enum logic [1:0] {
        TECS_MODE_CONT   = 2'b00,
        TECS_MODE_FAIL   = 2'b01,
        TECS_MODE_FORCED = 2'b10
    } tecs_mode_t;

endpackage : tecs_pkg

// ===== rtl/tecs_ms_timer.sv
`timescale 1ns/10ps
`include "tecs_params.svh"

module tecs_ms_timer #(
    parameter int unsigned TICK_CYCLES = 100000,
    parameter int unsigned MS_W        = 20
) (
    input  wire logic            ref_clk_in, // System clock.
    input  wire logic            rst_in,     // Async reset, active high.
    input  wire logic            load_in,    // Start a new count.
    input  wire logic [MS_W-1:0] value_in,   // Count in milliseconds.
    input  wire logic            abort_in,   // Stop counting.
    output logic                 done_out,   // One-cycle pulse at expiry.
    output logic                 busy_out    // Counting.
);

    localparam int TW = $clog2(TICK_CYCLES) + 1;

    logic [TW-1:0]   pre_reg;
    logic [MS_W-1:0] count_reg;

    // The prescaler restarts on load, so every count that runs to expiry lasts whole milliseconds exactly.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_reg   <= '0;
            count_reg <= '0;
            busy_out  <= 1'b0;
            done_out  <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (load_in) begin
                pre_reg   <= '0;
                count_reg <= (value_in == '0) ? MS_W'(1) : value_in;
                busy_out  <= 1'b1;
            end else if (abort_in) begin
                busy_out <= 1'b0;
            end else if (busy_out) begin
                if (pre_reg == TW'(TICK_CYCLES - 1)) begin
                    pre_reg <= '0;
                    if (count_reg == MS_W'(1)) begin
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                    end else begin
                        count_reg <= count_reg - MS_W'(1);
                    end
                end else begin
                    pre_reg <= pre_reg + TW'(1);
                end
            end
        end
    end

endmodule : tecs_ms_timer

// ===== verif/tecs_plc_model.sv
`timescale 1ns/10ps
// Controller on the far side: closes each start or stop contact for PULSE cycles.
module tecs_plc_model #(parameter int PULSE = 50) (
    input  wire logic clk_in,    // Bench clock.
    input  wire logic start_in,  // Request a start pulse.
    input  wire logic stop_in,   // Request a stop pulse.
    output logic      start_out, // Start pin, source wiring.
    output logic      stop_out   // Stop pin, source wiring.
);
    int st_cnt = 0;
    int sp_cnt = 0;
    // A full 5 ms hold, so a short request can never slip past the tester.
    always_ff @(posedge clk_in) begin
        st_cnt <= start_in ? PULSE : st_cnt - (st_cnt > 0);
        sp_cnt <= stop_in ? PULSE : sp_cnt - (sp_cnt > 0);
    end
    // A closed contact drives the pin high in source wiring.
    assign start_out = st_cnt > 0;
    assign stop_out  = sp_cnt > 0;
endmodule : tecs_plc_model

// ===== verif/tecs_sequencer_tb.sv
`timescale 1ns/10ps
`include "tecs_params.svh"
module tecs_sequencer_tb;
    import tecs_pkg::*;
    logic        ref_clk_in = 0, rst_in = 1, wr = 0, rd = 0, st_req = 0, sp_req = 0, vc = 0;
    logic        below = 1, pst = 0, psp = 0, fail = 0, st_pin, sp_pin, t_pin, hv, meas, disch;
    logic [7:0]  addr = 0;
    logic [31:0] wdat = 0, rdat, rd_data;
    logic [3:0]  cond = 4'h5, cond_l;
    tecs_state_t state;
    int          error_cnt = 0, comparisons = 0, n;
    // Free running clock, one ms is ten cycles in this bench.
    always #5 ref_clk_in = ~ref_clk_in;
    tecs_plc_model u_plc (.clk_in(ref_clk_in), .start_in(st_req), .stop_in(sp_req), .start_out(st_pin),
                          .stop_out(sp_pin));
    tecs_sequencer #(.CYCLES_PER_MS(10)) u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr),
        .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data), .start_pin_in(st_pin),
        .stop_pin_in(sp_pin), .cond_pin_in(cond), .below_10v_in(below), .panel_start_in(pst),
        .panel_stop_in(psp), .fail_judge_in(fail), .volt_change_in(vc), .test_pin_out(t_pin),
        .hv_on_out(hv), .meas_out(meas), .disch_out(disch), .cond_latched_out(cond_l), .state_out(state));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle; read data is taken in the cycle after the strobe.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        @(posedge ref_clk_in);
        wr <= 0;
        rd <= 0;
        #1 rdat = rd_data;
        @(posedge ref_clk_in);
    endtask : bus
    // One-cycle pulse on the selected inputs, mask order {vc, psp, fail, pst, sp_req, st_req}.
    task pulse(input logic [5:0] m);
        {vc, psp, fail, pst, sp_req, st_req} <= m;
        @(posedge ref_clk_in);
        {vc, psp, fail, pst, sp_req, st_req} <= 6'h00;
    endtask : pulse
    // Sample at the falling edge so outputs have settled; n counts cycles waited.
    task wait_st(input tecs_state_t s, input int lim);
        n = 0;
        @(negedge ref_clk_in);
        while (state !== s && n < lim) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk(state, s);
        @(posedge ref_clk_in);
    endtask : wait_st
    task end_of_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    // Watchdog, well beyond the seven thousand or so cycles the tests need.
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        error_cnt++;
        end_of_test();
    end
    // Test sequence.
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 0;
        @(posedge ref_clk_in);
        bus(0, `TECS_ADDR_DURATION, 0);
        chk(rdat, 32'h0000_0BB8);
        bus(0, 8'h14, 0);
        chk(rdat, 32'h0000_0000);
        chk(t_pin, 1);
        // Forced mode with a short duration enabled: only the stop may end this test.
        bus(1, `TECS_ADDR_CTRL, 32'h0000_0014);
        bus(1, `TECS_ADDR_DURATION, 32'h0000_002D);
        below <= 0;
        pulse(6'h01);
        wait_st(TECS_DELAY, 50);
        chk(t_pin, 0);
        cond <= 4'hA;
        wait_st(TECS_MEAS, 60);
        chk(n inside {[48:52]}, 1);
        wait_st(TECS_GAP, 320);
        chk(n inside {[298:302]}, 1);
        wait_st(TECS_MEAS, 220);
        chk(n inside {[198:202]}, 1);
        chk(cond_l, 4'h5);
        pulse(6'h02);
        wait_st(TECS_DISCH, 50);
        chk(t_pin, 1);
        below <= 1;
        wait_st(TECS_IDLE, 10);
        bus(1, `TECS_ADDR_CTRL, 32'h0000_002A);
        below <= 0;
        pulse(6'h04);
        wait_st(TECS_MEAS, 60);
        wait_st(TECS_GAP, 900);
        chk(n inside {[798:802]}, 1);
        pulse(6'h08);
        wait_st(TECS_DISCH, 3);
        chk(t_pin, 0);
        below <= 1;
        wait_st(TECS_IDLE, 10);
        chk(t_pin, 1);
        bus(1, `TECS_ADDR_CTRL, 32'h0000_000C);
        bus(1, `TECS_ADDR_DURATION, 32'h0000_002D);
        below <= 0;
        pulse(6'h04);
        wait_st(TECS_DELAY, 5);
        wait_st(TECS_DISCH, 470);
        chk(n inside {[445:455]}, 1);
        wait_st(TECS_IDLE, 220);
        chk(n inside {[198:202]}, 1);
        bus(0, `TECS_ADDR_STATUS, 0);
        chk(rdat[14], 1);
        // A start after a voltage change waits out the settle time; the panel stop then ends it.
        below <= 1;
        pulse(6'h20);
        @(posedge ref_clk_in);
        pulse(6'h04);
        wait_st(TECS_DELAY, 5100);
        chk(n inside {[4995:5005]}, 1);
        pulse(6'h10);
        wait_st(TECS_DISCH, 3);
        wait_st(TECS_IDLE, 10);
        bus(1, `TECS_ADDR_CTRL, 32'h0000_0040);
        bus(1, `TECS_ADDR_MANUAL, 32'h0000_0006);
        @(negedge ref_clk_in);
        chk({t_pin, hv, meas, disch}, 4'b0110);
        end_of_test();
    end
endmodule : tecs_sequencer_tb
